// [rtl/ser_cfg_defines.svh]
`ifndef SER_CFG_DEFINES_SVH
`define SER_CFG_DEFINES_SVH

// reset value of the setting registers and override flags
`define SER_CFG_RESET     6'h00
// pin synchroniser reset: power_down_n low, so the part starts powered down
`define SER_PIN_RESET     10'h000
// control filter: least pulse width in pixel clocks
`define SER_FILTER_CYCLES 2'h3
// serial frame: one start bit plus the 27-bit pixel word
`define SER_FRAME_BITS    5'h1c
// control bus target address for address code zero
`define SER_ADDR_BASE     7'h40
// words held between the pixel clock and the system clock
`define SER_FIFO_DEPTH    4
`define SER_WORD_BITS     27

`endif

// [rtl/ser_cfg_pkg.sv]
package ser_cfg_pkg;

  typedef enum logic [1:0] {
    MODE_CURRENT  = 2'b00,
    MODE_FILTERED = 2'b01,
    MODE_LEGACY_A = 2'b10,
    MODE_LEGACY_B = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    ST_DOWN  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } link_state_type;

  // one field per setting that a pin or the control bus may give
  typedef struct packed {
    mode_type mode;
    logic     swing;
    logic     emphasis;
    logic     rising;
    logic     self_test;
  } settings_type;

  typedef struct packed {
    logic [23:0] rgb;
    logic        hsync;
    logic        vsync;
    logic        valid;
  } pixel_type;

endpackage : ser_cfg_pkg

// [rtl/pixel_async_fifo.sv]
`timescale 1ns/1ns
module pixel_async_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input  wire logic             wr_clk_i,
  input  wire logic             rd_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wbin_q;
  logic [AW:0]      wgray_q;
  logic [AW:0]      rbin_q;
  logic [AW:0]      rgray_q;
  logic [AW:0]      wg1_q;
  logic [AW:0]      wg2_q;
  logic [AW:0]      rg1_q;
  logic [AW:0]      rg2_q;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // full when the write pointer is one lap ahead; the local gray write pointer is compared with the synced read pointer
  assign wr_ready_o = (wgray_q != (rg2_q ^ {2'b11, {(AW-1){1'b0}}}));
  assign rd_valid_o = (rgray_q != wg2_q);
  assign rd_data_o  = mem_q[rbin_q[AW-1:0]];

  // storage needs no reset; the pointers alone say what is valid
  always_ff @(posedge wr_clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem_q[wbin_q[AW-1:0]] <= wr_data_i;
    end
  end

  // write pointer
  always_ff @(posedge wr_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (wr_valid_i && wr_ready_o) begin
      wbin_q  <= wbin_q + 1'b1;
      wgray_q <= to_gray(wbin_q + 1'b1);
    end
  end

  // read pointer
  always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rbin_q  <= '0;
      rgray_q <= '0;
    end else if (rd_valid_o && rd_ready_i) begin
      rbin_q  <= rbin_q + 1'b1;
      rgray_q <= to_gray(rbin_q + 1'b1);
    end
  end

  // gray pointers cross two flops each way
  always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wg1_q <= '0;
      wg2_q <= '0;
    end else begin
      wg1_q <= wgray_q;
      wg2_q <= wg1_q;
    end
  end

  always_ff @(posedge wr_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rg1_q <= '0;
      rg2_q <= '0;
    end else begin
      rg1_q <= rgray_q;
      rg2_q <= rg1_q;
    end
  end

endmodule : pixel_async_fifo

// [rtl/serializer_control_config.sv]
`timescale 1ns/1ns
`include "ser_cfg_defines.svh"
// Overview of operation
// [R01] power_down_n high: run, serial output, multiplier on
// [R02] power_down_n low: both serial outputs held high
// [R03] powered down: multiplier loop off, current minimal
// [R04] power-down returns all setting registers to reset
// [R05] swing select 1 high swing, 0 low
// [R06] emphasis off when pin floats; low/register enables
// [R07] edge select 1: capture on rising pixel edge
// [R08] edge select 0: capture on falling pixel edge
// [R09] mode: 00 plain, 01 filtered, 10/11 legacy
// [R10] filter passes sync/valid pulses of three clocks
// [R11] source limits control toggles per 130 clocks
// [R12] bus address derived from address select level
// [R13] self test enable turns link test on
// [R14] board delays power-up release on slow supplies
// [R15] bus write overrides pin until next power-down
module serializer_control_config
  import ser_cfg_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         pclk_i,
  input  wire logic         power_down_n_i,
  input  wire logic         output_swing_select_i,
  input  wire logic         emphasis_control_i,
  input  wire logic         latch_edge_select_i,
  input  wire logic [1:0]   mode_select_i,
  input  wire logic         self_test_enable_i,
  input  wire logic [2:0]   bus_address_select_i,
  input  wire logic [23:0]  pixel_rgb_i,
  input  wire logic         horizontal_sync_i,
  input  wire logic         vertical_sync_i,
  input  wire logic         pixel_valid_i,
  input  wire logic         cfg_write_i,
  input  wire settings_type cfg_mask_i,
  input  wire settings_type cfg_data_i,
  output logic              dout_p_o,
  output logic              dout_n_o,
  output logic              pll_enable_o,
  output logic              swing_high_o,
  output logic              emphasis_on_o,
  output logic              rising_edge_o,
  output logic              filter_on_o,
  output mode_type          partner_mode_o,
  output logic              self_test_on_o,
  output logic [6:0]        bus_address_o,
  output logic              overflow_o
);

  logic [9:0]     pin_s1_q;
  logic [9:0]     pin_s2_q;
  logic           pd;
  logic           pd_prev_q;
  settings_type   pin_set;
  settings_type   eff;
  settings_type   cfg_q;
  settings_type   ovr_q;
  link_state_type state_q;
  logic [27:0]    shift_q;
  logic [4:0]     bits_q;
  logic           rd_valid;
  logic           rd_ready;
  pixel_type      rd_word;
  logic           ov1_q;
  logic           ov2_q;
  logic [2:0]     ps1_q;
  logic [2:0]     ps2_q;
  pixel_type      cap_p_q;
  pixel_type      cap_n_q;
  pixel_type      sel_q;
  logic [1:0]     flt_q;
  logic [1:0]     fcnt_q [2];
  logic           wr_valid_q;
  logic           wr_ready;
  pixel_type      word_q;
  logic           ovf_q;

  function automatic logic [6:0] addr_of(input logic [2:0] code);
    return `SER_ADDR_BASE + {4'h0, code};
  endfunction : addr_of

  // pins are asynchronous to sys_clk_i; only the second stage is read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= `SER_PIN_RESET;
      pin_s2_q <= `SER_PIN_RESET;
    end else begin
      pin_s1_q <= {power_down_n_i, output_swing_select_i, emphasis_control_i, latch_edge_select_i,
                   mode_select_i, self_test_enable_i, bus_address_select_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pd = ~pin_s2_q[9];

  // emphasis pin idles high through its pull-up, so a low level asks for emphasis
  always_comb begin
    pin_set.mode      = mode_type'(pin_s2_q[5:4]);
    pin_set.swing     = pin_s2_q[8];
    pin_set.emphasis  = ~pin_s2_q[7]; // R06
    pin_set.rising    = pin_s2_q[6];
    pin_set.self_test = pin_s2_q[3];
    eff = settings_type'((ovr_q & cfg_q) | (~ovr_q & pin_set)); // R15
  end

  // setting registers; power-down wins over a write in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= settings_type'(`SER_CFG_RESET);
      ovr_q <= settings_type'(`SER_CFG_RESET);
    end else if (pd) begin
      cfg_q <= settings_type'(`SER_CFG_RESET); // R04
      ovr_q <= settings_type'(`SER_CFG_RESET); // R04
    end else if (cfg_write_i) begin
      cfg_q <= settings_type'((cfg_q & ~cfg_mask_i) | (cfg_data_i & cfg_mask_i));
      ovr_q <= settings_type'(ovr_q | cfg_mask_i); // R15
    end
  end

  // decoded settings, each straight from a flop
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_enable_o   <= 1'b0;
      swing_high_o   <= 1'b0;
      emphasis_on_o  <= 1'b0;
      rising_edge_o  <= 1'b0;
      filter_on_o    <= 1'b0;
      partner_mode_o <= MODE_CURRENT;
      self_test_on_o <= 1'b0;
    end else begin
      pll_enable_o   <= ~pd; // R01 R03
      swing_high_o   <= eff.swing; // R05
      emphasis_on_o  <= eff.emphasis; // R06
      rising_edge_o  <= eff.rising;
      filter_on_o    <= (eff.mode == MODE_FILTERED); // R09
      partner_mode_o <= eff.mode; // R09
      self_test_on_o <= eff.self_test; // R13
    end
  end

  // address level is caught at each release of power-down
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pd_prev_q     <= 1'b1;
      bus_address_o <= `SER_ADDR_BASE;
    end else begin
      pd_prev_q <= pd;
      if (pd_prev_q && !pd) begin
        bus_address_o <= addr_of(pin_s2_q[2:0]); // R12
      end
    end
  end

  // while powered down the fifo is drained so stale pixels never reach the line
  assign rd_ready = pd || (state_q == ST_IDLE);

  // serial line: start bit then the pixel word, msb first
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q  <= ST_DOWN;
      shift_q  <= '0;
      bits_q   <= '0;
      dout_p_o <= 1'b1;
      dout_n_o <= 1'b1;
    end else if (pd) begin
      state_q  <= ST_DOWN;
      dout_p_o <= 1'b1; // R02
      dout_n_o <= 1'b1; // R02
    end else begin
      case (state_q)
        ST_DOWN: begin
          state_q  <= ST_IDLE;
          dout_p_o <= 1'b0;
          dout_n_o <= 1'b1;
        end
        ST_IDLE: begin
          dout_p_o <= 1'b0;
          dout_n_o <= 1'b1;
          if (rd_valid) begin
            shift_q <= {1'b1, rd_word};
            bits_q  <= `SER_FRAME_BITS;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          dout_p_o <= shift_q[27];
          dout_n_o <= ~shift_q[27];
          shift_q  <= {shift_q[26:0], 1'b0};
          bits_q   <= bits_q - 5'h01;
          if (bits_q == 5'h01) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_DOWN;
      endcase
    end
  end

  // overflow level crosses back from the pixel domain
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov1_q      <= 1'b0;
      ov2_q      <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      ov1_q      <= ovf_q;
      ov2_q      <= ov1_q;
      overflow_o <= ov2_q;
    end
  end

  // run, edge and filter levels cross into the pixel domain
  always_ff @(posedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ps1_q <= 3'h0;
      ps2_q <= 3'h0;
    end else begin
      ps1_q <= {pll_enable_o, rising_edge_o, filter_on_o};
      ps2_q <= ps1_q;
    end
  end

  // both edges capture; the selected one is registered at the next rising pixel edge
  always_ff @(posedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_p_q <= '0;
    end else begin
      cap_p_q <= {pixel_rgb_i, horizontal_sync_i, vertical_sync_i, pixel_valid_i}; // R07
    end
  end

  always_ff @(negedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_n_q <= '0;
    end else begin
      cap_n_q <= {pixel_rgb_i, horizontal_sync_i, vertical_sync_i, pixel_valid_i}; // R08
    end
  end

  always_ff @(posedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q <= '0;
    end else begin
      sel_q <= ps2_q[1] ? cap_p_q : cap_n_q; // R07 R08
    end
  end

  // control filter: a new level passes only once seen three clocks running
  always_ff @(posedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flt_q     <= 2'h0;
      fcnt_q[0] <= 2'h0;
      fcnt_q[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!ps2_q[0]) begin
          flt_q[i]  <= (i == 1) ? sel_q.hsync : sel_q.valid;
          fcnt_q[i] <= 2'h0;
        end else if (((i == 1) ? sel_q.hsync : sel_q.valid) == flt_q[i]) begin
          fcnt_q[i] <= 2'h0;
        end else if (fcnt_q[i] == `SER_FILTER_CYCLES - 2'h1) begin
          flt_q[i]  <= ~flt_q[i]; // R10
          fcnt_q[i] <= 2'h0;
        end else begin
          fcnt_q[i] <= fcnt_q[i] + 2'h1; // R10
        end
      end
    end
  end

  // video cannot be stalled: a full fifo holds the pending word and drops new ones
  always_ff @(posedge pclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_valid_q <= 1'b0;
      word_q     <= '0;
      ovf_q      <= 1'b0;
    end else if (!ps2_q[2]) begin
      wr_valid_q <= 1'b0;
      ovf_q      <= 1'b0;
    end else if (!wr_valid_q || wr_ready) begin
      wr_valid_q <= 1'b1;
      word_q     <= {sel_q.rgb, flt_q[1], sel_q.vsync, flt_q[0]};
    end else begin
      ovf_q <= 1'b1;
    end
  end

  pixel_async_fifo #(
    .WIDTH(`SER_WORD_BITS),
    .DEPTH(`SER_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i  (pclk_i),
    .rd_clk_i  (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .wr_valid_i(wr_valid_q),
    .wr_ready_o(wr_ready),
    .wr_data_i (word_q),
    .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready),
    .rd_data_o (rd_word)
  );

  property p_run_pll;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !pd |=> pll_enable_o;
  endproperty
  a_run_pll: assert property (p_run_pll) else $error("pll off while running"); // R01

  property p_pd_dout;
    @(posedge sys_clk_i) disable iff (!rst_b_i) pd |=> dout_p_o && dout_n_o;
  endproperty
  a_pd_dout: assert property (p_pd_dout) else $error("serial outputs not high in power-down"); // R02

  property p_pd_pll;
    @(posedge sys_clk_i) disable iff (!rst_b_i) pd ##1 pd |=> !pll_enable_o && state_q == ST_DOWN;
  endproperty
  a_pd_pll: assert property (p_pd_pll) else $error("pll on in power-down"); // R03

  property p_pd_clear;
    @(posedge sys_clk_i) disable iff (!rst_b_i) pd |=> ovr_q == 6'h00 && cfg_q == 6'h00;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("settings kept across power-down"); // R04

  property p_swing;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!ovr_q.swing) |=> swing_high_o == $past(pin_s2_q[8]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing does not follow pin"); // R05

  property p_emph;
    @(posedge sys_clk_i) disable iff (!rst_b_i) (!ovr_q.emphasis && pin_s2_q[7]) |=> !emphasis_on_o;
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis on with floating pin"); // R06

  property p_edge;
    @(posedge pclk_i) disable iff (!rst_b_i) ps2_q[1] |=> sel_q.rgb == $past(pixel_rgb_i, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("rising capture mismatch"); // R07

  property p_mode;
    @(posedge sys_clk_i) disable iff (!rst_b_i) (ovr_q == 6'h00) |=>
      filter_on_o == ($past(pin_s2_q[5:4]) == 2'h1) && partner_mode_o == $past(pin_s2_q[5:4]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong"); // R09

  property p_filter;
    @(posedge pclk_i) disable iff (!rst_b_i) ($past(ps2_q[0]) && $past(ps2_q[0], 3) && $changed(flt_q[1])) |->
      flt_q[1] == $past(sel_q.hsync, 1) && flt_q[1] == $past(sel_q.hsync, 2) &&
      flt_q[1] == $past(sel_q.hsync, 3);
  endproperty
  a_filter: assert property (p_filter) else $error("short sync pulse passed filter"); // R10

  property p_addr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (pd_prev_q && !pd) |=> bus_address_o == `SER_ADDR_BASE + {4'h0, $past(pin_s2_q[2:0])};
  endproperty
  a_addr: assert property (p_addr) else $error("bus address not caught"); // R12

  property p_bist;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !ovr_q.self_test |=> self_test_on_o == $past(pin_s2_q[3]);
  endproperty
  a_bist: assert property (p_bist) else $error("self test does not follow pin"); // R13

  property p_override;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (cfg_write_i && cfg_mask_i.swing && !pd) ##1 (!cfg_write_i && !pd) |=>
      swing_high_o == $past(cfg_data_i.swing, 2);
  endproperty
  a_override: assert property (p_override) else $error("written swing not applied"); // R15

  c_write: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) cfg_write_i && !pd);
  c_frame: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) state_q == ST_IDLE ##1 state_q == ST_SHIFT);
  c_full: cover property (@(posedge pclk_i) disable iff (!rst_b_i) wr_valid_q && !wr_ready);
  c_pd: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) !pd ##1 pd);

endmodule : serializer_control_config

// [test/video_source_model.sv]
`timescale 1ns/1ns
// far-side video source: one pixel per pixel clock, sync pulses on request
module video_source_model
  import ser_cfg_pkg::*;
(
  input  wire logic        pclk_i,
  input  wire logic        rising_i,
  input  wire logic [23:0] rgb_i,
  input  wire logic        pulse_req_i,
  input  wire logic [1:0]  pulse_len_i,
  output logic [23:0]      pixel_rgb_o,
  output logic             horizontal_sync_o,
  output logic             vertical_sync_o,
  output logic             pixel_valid_o
);
  int gap_q  = 130;
  int left_q = 0;

  // quiet bus until the first launch edge
  initial begin
    pixel_rgb_o = 24'h000000;
    horizontal_sync_o = 1'b0;
    vertical_sync_o = 1'b0;
    pixel_valid_o = 1'b0;
  end

  // launch half a pixel clock before capture, so setup and hold stay wide
  always @(posedge pclk_i or negedge pclk_i) begin
    if (pclk_i !== rising_i) begin
      gap_q = gap_q + 1;
      if (left_q > 0) begin
        left_q = left_q - 1;
      end else if (pulse_req_i && gap_q >= 130) begin
        left_q = pulse_len_i;
        gap_q  = 0;
      end
      horizontal_sync_o <= (left_q > 0);
      vertical_sync_o   <= 1'b0;
      pixel_valid_o     <= 1'b1;
      pixel_rgb_o       <= rgb_i;
    end
  end
endmodule : video_source_model

// [test/testbench.sv]
`timescale 1ns/1ns
module testbench
  import ser_cfg_pkg::*;
;
  logic         sys_clk   = 1'b0;
  logic         pclk      = 1'b0;
  logic         rst_b     = 1'b1;
  logic         pd_n      = 1'b0;
  logic         swing     = 1'b0;
  logic         emph      = 1'b1;
  logic         edge_sel  = 1'b1;
  logic         self_test = 1'b0;
  logic [1:0]   mode      = 2'b00;
  logic [2:0]   addr_code = 3'h0;
  logic [23:0]  rgb_src   = 24'h111111;
  logic         req       = 1'b0;
  logic [1:0]   plen      = 2'h1;
  logic         cfg_wr    = 1'b0;
  settings_type cfg_mask  = '0;
  settings_type cfg_data  = '0;
  logic [23:0]  v_rgb;
  logic         v_hsync, v_vsync, v_valid;
  logic         dp, dn, pll, sw_o, em_o, re_o, fl_o, st_o, ovf, seen;
  mode_type     pm_o;
  logic [6:0]   addr_o;
  logic [26:0]  w;
  int           failures  = 0;
  int           checks    = 0;

  always #2 sys_clk = ~sys_clk;
  // pixel clock offset by 37 ns so its edges never meet the system clock's
  initial begin
    #37;
    forever #80 pclk = ~pclk;
  end

  serializer_control_config i_serializer_control_config (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .pclk_i(pclk), .power_down_n_i(pd_n),
    .output_swing_select_i(swing), .emphasis_control_i(emph), .latch_edge_select_i(edge_sel),
    .mode_select_i(mode), .self_test_enable_i(self_test), .bus_address_select_i(addr_code),
    .pixel_rgb_i(v_rgb), .horizontal_sync_i(v_hsync), .vertical_sync_i(v_vsync), .pixel_valid_i(v_valid),
    .cfg_write_i(cfg_wr), .cfg_mask_i(cfg_mask), .cfg_data_i(cfg_data),
    .dout_p_o(dp), .dout_n_o(dn), .pll_enable_o(pll), .swing_high_o(sw_o),
    .emphasis_on_o(em_o), .rising_edge_o(re_o), .filter_on_o(fl_o), .partner_mode_o(pm_o),
    .self_test_on_o(st_o), .bus_address_o(addr_o), .overflow_o(ovf));

  video_source_model i_video_source_model (
    .pclk_i(pclk), .rising_i(re_o), .rgb_i(rgb_src), .pulse_req_i(req), .pulse_len_i(plen),
    .pixel_rgb_o(v_rgb), .horizontal_sync_o(v_hsync), .vertical_sync_o(v_vsync), .pixel_valid_o(v_valid));

  function automatic logic [26:0] exp_frame(input logic [23:0] rgb, input logic hsync);
    return {rgb, hsync, 1'b0, 1'b1};
  endfunction : exp_frame

  function automatic logic exp_filter(input logic [1:0] m);
    return m == 2'b01;
  endfunction : exp_filter

  task automatic complete_run();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // inputs set after step move 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic cfg(input settings_type m, input settings_type d);
    cfg_wr = 1'b1;
    cfg_mask = m;
    cfg_data = d;
    step(1);
    cfg_wr = 1'b0;
  endtask : cfg

  task automatic set_pins(input logic [1:0] m);
    {swing, emph, edge_sel, self_test} = 4'($urandom);
    mode = m;
    step(5);
    chk(sw_o, swing);
    chk(em_o, !emph);
    chk(re_o, edge_sel);
    chk(pm_o, mode);
    chk(fl_o, exp_filter(mode));
    chk(st_o, self_test);
  endtask : set_pins

  // idle is a run of zeros; payload never holds five zeros in a row
  task automatic get_frame(output logic [26:0] f);
    int z, n;
    z = 0;
    n = 0;
    while ((z < 5 || dp !== 1'b1) && n < 500) begin
      @(negedge sys_clk);
      n++;
      z = (dp === 1'b0) ? z + 1 : (z < 5 ? 0 : z);
    end
    chk(n < 500, 1'b1);
    chk({dp, dn}, 2'b10);
    for (int i = 26; i >= 0; i--) begin
      @(negedge sys_clk);
      f[i] = dp;
    end
  endtask : get_frame

  task automatic pulse_scan(input logic [1:0] m, input logic [1:0] len, output logic hit);
    int n;
    n = 0;
    mode = m;
    plen = len;
    step(5);
    req = 1'b1;
    while (v_hsync !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 8000, 1'b1);
    step(1);
    req = 1'b0;
    hit = 1'b0;
    // the filter and the fifo delay a pulse by several pixel clocks
    repeat (12) begin
      get_frame(w);
      hit = hit | w[2];
    end
  endtask : pulse_scan

  // watchdog sized well beyond the expected run
  initial begin
    #400000;
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h1daf));
    // a real falling edge, so pixel-clock flops reset before their clock first ticks
    #1;
    rst_b = 1'b0;
    step(6);
    rst_b = 1'b1;
    step(4);
    chk({dp, dn}, 2'b11);
    chk(pll, 1'b0);
    addr_code = 3'($urandom);
    pd_n = 1'b1;
    step(6);
    chk(pll, 1'b1);
    chk(addr_o, 7'h40 + 7'(addr_code));
    for (int i = 0; i < 12; i++) begin
      set_pins(i < 4 ? 2'(i) : 2'($urandom));
    end
    // overrides on swing and mode, then a pin change that must not show
    set_pins(2'b00);
    cfg(settings_type'(6'h38), settings_type'({2'b10, !swing, 3'b000}));
    step(3);
    chk(sw_o, !swing);
    mode = 2'b01;
    step(5);
    chk(pm_o, 2'b10);
    pd_n = 1'b0;
    step(5);
    chk({dp, dn}, 2'b11);
    chk(pll, 1'b0);
    cfg(settings_type'(6'h38), settings_type'({2'b11, !swing, 3'b000}));
    addr_code = 3'($urandom);
    pd_n = 1'b1;
    step(6);
    chk(pm_o, mode);
    chk(sw_o, swing);
    chk(addr_o, 7'h40 + 7'(addr_code));
    // serial frames under both capture edges; first frames may be stale
    mode = 2'b00;
    for (int e = 1; e >= 0; e--) begin
      edge_sel = e[0];
      rgb_src = 24'($urandom) | 24'h111111;
      step(5);
      repeat (8) get_frame(w);
      chk(w, exp_frame(rgb_src, 1'b0));
    end
    // short pulse blocked when filtered, long one passes, unfiltered passes
    for (int k = 0; k < 3; k++) begin
      pulse_scan(k == 2 ? 2'b00 : 2'b01, k == 1 ? 2'h3 : 2'h1, seen);
      chk(seen, k != 0);
    end
    chk(ovf, 1'b0);
    complete_run();
  end
endmodule : testbench
